// >>> dv/dcrc_chk.sv
// port assertions for the dma crc generator
`timescale 1ns/10ps
`include "dcrc_regs.svh"
module dcrc_chk
  import dcrc_pkg::*;
(
  // clock, reset, register port
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // channel side
  input wire logic        bus_access_in,
  input wire logic [31:0] bus_addr_in,
  input wire logic        xfer_valid_in,
  input wire logic [2:0]  xfer_chan_in,
  input wire logic [31:0] xfer_data_in,
  input wire logic        block_done_in,
  input wire logic [2:0]  block_done_chan_in,
  input wire logic [31:0] chan_dest_start_in,
  // outputs watched
  input wire logic        crc_route_out,
  input wire logic        dest_wr_out,
  input wire logic [31:0] dest_data_out,
  input wire logic        result_wr_out,
  input wire logic [31:0] result_addr_out
);
  logic [31:0] ctl_q;
  // decoded accesses and the expected control word
  wire ctl_wr = reg_wr_in && reg_addr_in == `DCRC_OFS_CONTROL;
  wire [31:0] ctl_new = reg_wdata_in & `DCRC_CONTROL_MASK &
                        ~{25'h0, reg_wdata_in[27], 6'h0};
  wire rd_ctl = reg_rd_in && reg_addr_in == `DCRC_OFS_CONTROL;
  wire rd_val = reg_rd_in && reg_addr_in == `DCRC_OFS_VALUE;
  wire rd_adr = reg_rd_in && reg_addr_in == `DCRC_OFS_LAST_ADDR;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // shadow of the control word
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctl_q <= 32'h0000_0000;
    end else if (ctl_wr) begin
      ctl_q <= ctl_new;
    end
  end
  // antecedents: bus access then read, and block completion
  sequence s_bus_then_rd;
    bus_access_in ##1 (!bus_access_in && !reg_rd_in)
      ##1 (!bus_access_in && rd_adr);
  endsequence
  sequence s_done;
    block_done_in && ctl_q[7] && ctl_q[6] && block_done_chan_in == ctl_q[2:0];
  endsequence
  chk_last_addr: assert property (
    s_bus_then_rd |=> reg_rdata_out == $past(bus_addr_in, 3))
    else $error("last address read wrong");
  chk_route_match: assert property (
    crc_route_out == (ctl_q[7] && xfer_chan_in == ctl_q[2:0]))
    else $error("routing status wrong");
  chk_dest_write: assert property (
    xfer_valid_in && !(crc_route_out && ctl_q[6]) |=> dest_wr_out)
    else $error("destination write missing");
  chk_append_hold: assert property (
    xfer_valid_in && crc_route_out && ctl_q[6] |=> !dest_wr_out)
    else $error("append mode wrote destination");
  chk_raw_data: assert property (
    xfer_valid_in && !(crc_route_out && ctl_q[27])
      |=> dest_data_out == $past(xfer_data_in))
    else $error("destination data altered");
  chk_result_write: assert property (
    s_done |=> result_wr_out && result_addr_out == $past(chan_dest_start_in))
    else $error("append result write wrong");
  chk_ctl_unused: assert property (
    rd_ctl |=> (reg_rdata_out & ~`DCRC_CONTROL_MASK) == 32'h0)
    else $error("unused control bit set");
  chk_no_app_wbo: assert property (
    rd_ctl |=> !(reg_rdata_out[27] && reg_rdata_out[6]))
    else $error("append set beside write reorder");
  chk_ip_upper: assert property (
    rd_val && ctl_q[5] |=> reg_rdata_out[31:16] == 16'h0)
    else $error("ip value upper half set");
  chk_poly_len_minus_one_mask: assert property (
    rd_val && !ctl_q[5]
      |=> (reg_rdata_out >> (6'(ctl_q[12:8]) + 6'h1)) == 32'h0)
    else $error("value bits above length set");
endmodule
bind dcrc_top dcrc_chk chk_u (.*);

// >>> dv/dcrc_dma_model.sv
// dma channel side model: bus accesses, source words, block completion
`timescale 1ns/10ps
module dcrc_dma_model (
  // clock
  input  wire logic        clk_in,
  // signals toward the crc unit
  output logic             bus_access_in,
  output logic [31:0]      bus_addr_in,
  output logic             xfer_valid_in,
  output logic [2:0]       xfer_chan_in,
  output logic [31:0]      xfer_data_in,
  output logic [3:0]       xfer_be_in,
  output logic             block_done_in,
  output logic [2:0]       block_done_chan_in,
  output logic [31:0]      chan_dest_start_in
);
  // idle levels
  initial begin
    bus_access_in = 1'b0;
    bus_addr_in = 32'h0000_0000;
    xfer_valid_in = 1'b0;
    xfer_chan_in = 3'h0;
    xfer_data_in = 32'h0000_0000;
    xfer_be_in = 4'h0;
    block_done_in = 1'b0;
    block_done_chan_in = 3'h0;
    chan_dest_start_in = 32'h0000_0000;
  end
  // one bus access; released address shows no stale value
  task automatic access(input logic [31:0] a);
    @(posedge clk_in);
    bus_access_in <= 1'b1;
    bus_addr_in <= a;
    @(posedge clk_in);
    bus_access_in <= 1'b0;
    bus_addr_in <= ~a;
  endtask
  // one source word with its byte lane enables
  task automatic send(input logic [2:0] c, input logic [31:0] d,
                      input logic [3:0] b);
    @(posedge clk_in);
    xfer_valid_in <= 1'b1;
    xfer_chan_in <= c;
    xfer_data_in <= d;
    xfer_be_in <= b;
    @(posedge clk_in);
    xfer_valid_in <= 1'b0;
    xfer_data_in <= ~d;
    #1;
  endtask
  // block completion with the channel start address
  task automatic done(input logic [2:0] c, input logic [31:0] a);
    @(posedge clk_in);
    block_done_in <= 1'b1;
    block_done_chan_in <= c;
    chan_dest_start_in <= a;
    @(posedge clk_in);
    block_done_in <= 1'b0;
    chan_dest_start_in <= ~a;
    #1;
  endtask
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the dma crc generator
`timescale 1ns/10ps
`include "dcrc_regs.svh"
module tb_top;
  import dcrc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in, reg_wr_in, reg_rd_in, bus_access_in, xfer_valid_in;
  logic block_done_in, crc_route_out, dest_wr_out, result_wr_out;
  logic [7:0] reg_addr_in;
  logic [2:0] xfer_chan_in, block_done_chan_in;
  logic [3:0] xfer_be_in, dest_be_out;
  logic [31:0] reg_wdata_in, reg_rdata_out, bus_addr_in, xfer_data_in;
  logic [31:0] chan_dest_start_in, dest_data_out, result_addr_out;
  logic [31:0] result_data_out, v, e;
  logic [31:0] ord [4] = '{32'h1122_3344, 32'h4433_2211,
                           32'h3344_1122, 32'h2211_4433};
  logic [15:0] lo, hi, sum;
  logic [16:0] s17;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;
  int p;
  // device and channel side
  dcrc_top dut_u (.*);
  dcrc_dma_model m_u (.*);
  // clock and hang guard
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      final_report();
    end
  end
  // comparison and verdict
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // register port cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  // reference shift register, one bit at a time
  function automatic logic [31:0] lfsr(logic [31:0] s, logic [31:0] d,
                                       int n, logic [31:0] t, logic r);
    logic [31:0] m;
    logic fb;
    m = 32'hffff_ffff >> (31 - n);
    s = s & m;
    for (int i = 0; i < 32; i++) begin
      fb = d[r ? i : 31 - i] ^ s[n];
      s = ({s[30:0], 1'b0} ^ (t & {32{fb}})) & m;
    end
    return s;
  endfunction
  // main sequence
  initial begin
    rst_n_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h0000_0000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 16), v);
      chk("reset read", v, 32'h0000_0000);
    end
    wr(`DCRC_OFS_CONTROL, 32'hffff_ffff);
    rd(`DCRC_OFS_CONTROL, v);
    chk("control mask", v, 32'h3900_1fa7);
    m_u.access(32'h1234_abcd);
    rd(`DCRC_OFS_LAST_ADDR, v);
    chk("last address", v, 32'h1234_abcd);
    for (int o = 0; o < 4; o++) begin
      wr(`DCRC_OFS_CONTROL, 32'h0800_0083 | (32'(o) << 28));
      m_u.send(3'h3, 32'h1122_3344, 4'hf);
      chk("reorder", dest_data_out, ord[o]);
    end
    wr(`DCRC_OFS_TAP, 32'h0000_1021);
    for (int k = 0; k < 2; k++) begin
      p = k ? 15 : 7;
      wr(`DCRC_OFS_CONTROL, 32'h83 | (32'(p) << 8) | (32'(k) << 24));
      wr(`DCRC_OFS_VALUE, 32'hffff_ffff);
      m_u.send(3'h3, 32'h1234_5678, 4'hf);
      rd(`DCRC_OFS_VALUE, v);
      e = lfsr(32'hffff_ffff, 32'h1234_5678, p, 32'h1021, k[0]);
      chk("lfsr", v, e);
    end
    for (int k = 0; k < 2; k++) begin
      wr(`DCRC_OFS_CONTROL, 32'h1fa3 | (32'(k) << 24));
      wr(`DCRC_OFS_VALUE, 32'h0000_ffff);
      rd(`DCRC_OFS_VALUE, v);
      chk("ip seed", v, 32'h0000_ffff);
      m_u.send(3'h3, 32'hc500_c030, 4'hf);
      rd(`DCRC_OFS_VALUE, v);
      lo = k ? 16'h0c03 : 16'hc030;
      hi = k ? 16'h00a3 : 16'hc500;
      s17 = 17'(lo) + 17'(hi);
      sum = s17[15:0] + 16'(s17[16]);
      chk("ip sum", v, {16'h0, ~sum});
    end
    wr(`DCRC_OFS_CONTROL, 32'h0000_0fc3);
    wr(`DCRC_OFS_VALUE, 32'hffff_ffff);
    m_u.send(3'h3, 32'h5555_aaaa, 4'hf);
    chk("append write", {31'h0, dest_wr_out}, 32'h0);
    m_u.send(3'h2, 32'h0f0f_f0f0, 4'h5);
    chk("unrouted data", dest_data_out, 32'h0f0f_f0f0);
    chk("unrouted lanes", {28'h0, dest_be_out}, 32'h5);
    m_u.done(3'h3, 32'h2000_0100);
    chk("result write", {31'h0, result_wr_out}, 32'h1);
    chk("result addr", result_addr_out, 32'h2000_0100);
    e = lfsr(32'hffff_ffff, 32'h5555_aaaa, 15, 32'h1021, 1'b0);
    chk("result data", result_data_out, e);
    final_report();
  end
endmodule

// >>> src/dcrc_pkg.sv
// types shared by the crc generator files
package dcrc_pkg;

  // byte order selections
  typedef enum logic [1:0] {
    DCRC_ORDER_KEEP  = 2'b00,
    DCRC_ORDER_WORD  = 2'b01,
    DCRC_ORDER_HALF  = 2'b10,
    DCRC_ORDER_INHW  = 2'b11
  } dcrc_byte_order_e;

  // computation type
  typedef enum logic {
    DCRC_TYPE_LFSR = 1'b0,
    DCRC_TYPE_IP   = 1'b1
  } dcrc_type_e;

  typedef logic [31:0] dcrc_word_t;

endpackage

// >>> src/dcrc_regs.svh
// register map, field positions, reset values and rule summary
// Function
// - read-only address of latest dma access
// - byte order 11 swaps bytes per half-word
// - byte order 10 swaps the two half-words
// - byte order 01 reverses all four bytes
// - byte order 00 keeps source order
// - write reorder bit reorders destination data
// - write reorder set blocks append mode
// - ip checksum reflected when bit order set
// - lfsr crc reflected when bit order set
// - poly length field is length minus one
// - ip mode ignores poly length
// - enable routes assigned channel through crc
// - append feeds crc, writes result at done
// - no append writes data to destination
// - type bit picks ip checksum or lfsr
// - channel select assigns unit to channel
// - unimplemented control bits read zero
// - value write seeds, read masked by length
// - ip value low 16 bits, ones complement
// - tap bits enable per-stage feedback xor
`ifndef DCRC_REGS_SVH
`define DCRC_REGS_SVH

// register byte offsets
`define DCRC_OFS_LAST_ADDR   8'h00
`define DCRC_OFS_CONTROL     8'h10
`define DCRC_OFS_VALUE       8'h20
`define DCRC_OFS_TAP         8'h30

// control field positions
`define DCRC_ORDER_HI        29
`define DCRC_ORDER_LO        28
`define DCRC_WREORD_BIT      27
`define DCRC_REFLECT_BIT     24
`define DCRC_POLY_HI         12
`define DCRC_POLY_LO         8
`define DCRC_EN_BIT          7
`define DCRC_APP_BIT         6
`define DCRC_TYP_BIT         5
`define DCRC_CH_HI           2
`define DCRC_CH_LO           0

// implemented control bits
`define DCRC_CONTROL_MASK    32'h3900_1fe7

// reset values
`define DCRC_RST_LAST_ADDR   32'h0000_0000
`define DCRC_RST_CONTROL     32'h0000_0000
`define DCRC_RST_VALUE       32'h0000_0000
`define DCRC_RST_TAP         32'h0000_0000

`endif

// >>> src/dcrc_reorder.sv
// byte lane reordering of one data word with its lane enables
`timescale 1ns/10ps
module dcrc_reorder
  import dcrc_pkg::*;
(
  // selection
  input  wire dcrc_byte_order_e order_in,
  // source word
  input  wire logic [31:0]      data_in,
  input  wire logic [3:0]       be_in,
  // reordered word
  output logic      [31:0]      data_out,
  output logic      [3:0]       be_out
);

  // lane swap pattern, xor of the lane index
  logic [1:0] lane_xor;

  assign lane_xor = (order_in == DCRC_ORDER_WORD) ? 2'h3 :
                    (order_in == DCRC_ORDER_HALF) ? 2'h2 :
                    (order_in == DCRC_ORDER_INHW) ? 2'h1 :
                    2'h0;

  // each output lane picks its source lane
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      logic [1:0] src;
      assign src = 2'(g) ^ lane_xor;
      assign data_out[8*g +: 8] = data_in[8*src +: 8];
      assign be_out[g]          = be_in[src];
    end
  endgenerate

endmodule

// >>> src/dcrc_top.sv
// dma crc generator with control, value, tap and debug address registers
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "dcrc_regs.svh"
module dcrc_top
  import dcrc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // dma bus access monitor
  input  wire logic        bus_access_in,
  input  wire logic [31:0] bus_addr_in,
  // channel data path from source reads
  input  wire logic        xfer_valid_in,
  input  wire logic [2:0]  xfer_chan_in,
  input  wire logic [31:0] xfer_data_in,
  input  wire logic [3:0]  xfer_be_in,
  // block completion
  input  wire logic        block_done_in,
  input  wire logic [2:0]  block_done_chan_in,
  input  wire logic [31:0] chan_dest_start_in,
  // routing status
  output logic             crc_route_out,
  // destination data write
  output logic             dest_wr_out,
  output logic      [31:0] dest_data_out,
  output logic      [3:0]  dest_be_out,
  // appended result write
  output logic             result_wr_out,
  output logic      [31:0] result_addr_out,
  output logic      [31:0] result_data_out
);

  // registers
  logic [31:0] last_addr_reg;
  logic [31:0] last_addr_next;
  logic [31:0] control_reg;
  logic [31:0] control_next;
  logic [31:0] value_reg;
  logic [31:0] value_next;
  logic [31:0] tap_reg;
  logic [31:0] tap_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        dest_wr_reg;
  logic [31:0] dest_data_reg;
  logic [3:0]  dest_be_reg;
  logic        result_wr_reg;
  logic [31:0] result_addr_reg;
  logic [31:0] result_data_reg;

  // control fields
  dcrc_byte_order_e byte_order_sel;
  dcrc_type_e       checksum_type_sel;
  logic             write_reorder_en;
  logic             bit_reflect_sel;
  logic [4:0]       poly_len_minus_one;
  logic             crc_unit_enable;
  logic             append_result_mode;
  logic [2:0]       crc_channel_sel;

  assign byte_order_sel =
    dcrc_byte_order_e'(control_reg[`DCRC_ORDER_HI:`DCRC_ORDER_LO]);
  assign write_reorder_en   = control_reg[`DCRC_WREORD_BIT];
  assign bit_reflect_sel    = control_reg[`DCRC_REFLECT_BIT];
  assign poly_len_minus_one = control_reg[`DCRC_POLY_HI:`DCRC_POLY_LO];
  assign crc_unit_enable    = control_reg[`DCRC_EN_BIT];
  assign append_result_mode = control_reg[`DCRC_APP_BIT];
  assign checksum_type_sel  = dcrc_type_e'(control_reg[`DCRC_TYP_BIT]);
  assign crc_channel_sel    = control_reg[`DCRC_CH_HI:`DCRC_CH_LO];

  // register address decode
  wire hit_last_addr = (reg_addr_in == `DCRC_OFS_LAST_ADDR);
  wire hit_control   = (reg_addr_in == `DCRC_OFS_CONTROL);
  wire hit_value     = (reg_addr_in == `DCRC_OFS_VALUE);
  wire hit_tap       = (reg_addr_in == `DCRC_OFS_TAP);
  wire wr_control    = reg_wr_in & hit_control;
  wire wr_value      = reg_wr_in & hit_value;
  wire wr_tap        = reg_wr_in & hit_tap;

  // transfer of the assigned channel while enabled
  wire is_ip   = (checksum_type_sel == DCRC_TYPE_IP);
  wire routed  = crc_unit_enable & (xfer_chan_in == crc_channel_sel);
  wire feed    = xfer_valid_in & routed;
  wire done_ok = block_done_in & crc_unit_enable & append_result_mode &
                 (block_done_chan_in == crc_channel_sel);

  assign crc_route_out = routed;

  // reordered copy of the source word
  logic [31:0] ord_data;
  logic [3:0]  ord_be;

  dcrc_reorder u_reorder (
    .order_in (byte_order_sel),
    .data_in  (xfer_data_in),
    .be_in    (xfer_be_in),
    .data_out (ord_data),
    .be_out   (ord_be)
  );

  // stage mask: stages 0 to length minus one take part
  logic [31:0] len_mask;

  always_comb begin
    len_mask = 32'h0000_0000;
    for (int i = 0; i < 32; i++) begin
      if (5'(i) <= poly_len_minus_one) begin
        len_mask[i] = 1'b1;
      end
    end
  end

  // lfsr over the enabled lanes, one bit per step
  logic [31:0] lfsr_next;

  always_comb begin
    logic [4:0]  idx;
    logic        fb;
    logic [31:0] shifted;
    idx       = 5'h00;
    fb        = 1'b0;
    shifted   = 32'h0000_0000;
    lfsr_next = value_reg;
    for (int b = 0; b < 32; b++) begin
      // reflected takes bit 0 first, else bit 31 first
      idx = bit_reflect_sel ? 5'(b) : 5'(31 - b);
      if (ord_be[idx[4:3]]) begin
        fb = ord_data[idx] ^ lfsr_next[poly_len_minus_one];
        // each tap bit xors feedback into its stage
        shifted   = {lfsr_next[30:0], 1'b0} ^ (tap_reg & {32{fb}});
        lfsr_next = shifted & len_mask;
      end
    end
  end

  // ip header half-words, disabled lanes as zero
  logic [15:0] half_lo;
  logic [15:0] half_hi;
  logic [15:0] add_lo;
  logic [15:0] add_hi;

  assign half_lo = {ord_be[1] ? ord_data[15:8]  : 8'h00,
                    ord_be[0] ? ord_data[7:0]   : 8'h00};
  assign half_hi = {ord_be[3] ? ord_data[31:24] : 8'h00,
                    ord_be[2] ? ord_data[23:16] : 8'h00};

  // reflected mode bit-reverses each half-word
  always_comb begin
    add_lo = half_lo;
    add_hi = half_hi;
    if (bit_reflect_sel) begin
      for (int i = 0; i < 16; i++) begin
        add_lo[i] = half_lo[15 - i];
        add_hi[i] = half_hi[15 - i];
      end
    end
  end

  // ones complement sum with end-around carry
  logic [16:0] sum_a;
  logic [15:0] sum_a_wrap;
  logic [16:0] sum_b;
  logic [15:0] ip_next;

  assign sum_a      = {1'b0, value_reg[15:0]} + {1'b0, add_lo};
  assign sum_a_wrap = sum_a[15:0] + {15'h0000, sum_a[16]};
  assign sum_b      = {1'b0, sum_a_wrap} + {1'b0, add_hi};
  assign ip_next    = sum_b[15:0] + {15'h0000, sum_b[16]};

  // value as software sees it
  wire [31:0] value_view = is_ip ? {16'h0000, ~value_reg[15:0]}
                                 : (value_reg & len_mask);

  // control write, append held off while write reorder is set
  always_comb begin
    control_next = control_reg;
    if (wr_control) begin
      control_next = reg_wdata_in & `DCRC_CONTROL_MASK;
      if (reg_wdata_in[`DCRC_WREORD_BIT]) begin
        control_next[`DCRC_APP_BIT] = 1'b0;
      end
    end
  end

  // value: software seed wins over a data update
  always_comb begin
    value_next = value_reg;
    if (wr_value) begin
      if (is_ip) begin
        value_next = {16'h0000, ~reg_wdata_in[15:0]};
      end else begin
        value_next = reg_wdata_in & len_mask;
      end
    end else if (feed) begin
      if (is_ip) begin
        value_next = {16'h0000, ip_next};
      end else begin
        value_next = lfsr_next;
      end
    end
  end

  // tap register and debug address
  assign tap_next       = wr_tap ? reg_wdata_in : tap_reg;
  assign last_addr_next = bus_access_in ? bus_addr_in : last_addr_reg;

  // read data mux, unmapped reads zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_rd_in) begin
      case (1'b1)
        hit_last_addr: rdata_next = last_addr_reg;
        hit_control:   rdata_next = control_reg;
        hit_value:     rdata_next = value_view;
        hit_tap:       rdata_next = tap_reg;
        default:       rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // destination data, unrouted transfers pass unchanged
  wire        dest_wr_next =
    xfer_valid_in & ~(routed & append_result_mode);
  wire [31:0] dest_data_next =
    (routed & write_reorder_en) ? ord_data : xfer_data_in;
  wire [3:0]  dest_be_next =
    (routed & write_reorder_en) ? ord_be : xfer_be_in;

  // register state
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      last_addr_reg <= `DCRC_RST_LAST_ADDR;
      control_reg   <= `DCRC_RST_CONTROL;
      value_reg     <= `DCRC_RST_VALUE;
      tap_reg       <= `DCRC_RST_TAP;
      rdata_reg     <= 32'h0000_0000;
    end else begin
      last_addr_reg <= last_addr_next;
      control_reg   <= control_next;
      value_reg     <= value_next;
      tap_reg       <= tap_next;
      rdata_reg     <= rdata_next;
    end
  end

  // destination write stage
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      dest_wr_reg   <= 1'b0;
      dest_data_reg <= 32'h0000_0000;
      dest_be_reg   <= 4'h0;
    end else begin
      dest_wr_reg   <= dest_wr_next;
      dest_data_reg <= dest_data_next;
      dest_be_reg   <= dest_be_next;
    end
  end

  // appended result write at block completion
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      result_wr_reg   <= 1'b0;
      result_addr_reg <= 32'h0000_0000;
      result_data_reg <= 32'h0000_0000;
    end else begin
      result_wr_reg <= done_ok;
      if (done_ok) begin
        result_addr_reg <= chan_dest_start_in;
        result_data_reg <= value_view;
      end
    end
  end

  // outputs
  assign reg_rdata_out   = rdata_reg;
  assign dest_wr_out     = dest_wr_reg;
  assign dest_data_out   = dest_data_reg;
  assign dest_be_out     = dest_be_reg;
  assign result_wr_out   = result_wr_reg;
  assign result_addr_out = result_addr_reg;
  assign result_data_out = result_data_reg;

endmodule
